//--- dv/led_host.sv
// Purpose: host model driving the command line and decoded commands
// Assumes: inputs change at the falling edge of clk
// Notes:   one tick is tk clocks of the shortened time base
`timescale 1ns/10ps

module led_host #(
  parameter int tk = 4 // clocks per time base tick
) (
  // clock
  input  wire logic clk,
  // command side
  output logic      ctrl,
  output logic      train_start,
  output logic      train_end
);
  // idle line low, no command pending
  initial begin
    ctrl = 1'b0;
    train_start = 1'b0;
    train_end = 1'b0;
  end

  // one-cycle decoded command, start or end of training
  task automatic cmd(input logic fin);
    @(negedge clk);
    train_start = !fin;
    train_end = fin;
    @(negedge clk);
    train_start = 1'b0;
    train_end = 1'b0;
  endtask

  // set the line level and keep it for a number of ticks
  task automatic hold(input logic v, input int ticks);
    @(negedge clk);
    ctrl = v;
    repeat (ticks * tk) @(negedge clk);
  endtask
endmodule

//--- dv/led_training_timeout_capture_tb.sv
// Purpose: self-checking bench of the training capture block
// Assumes: tick shortened to four clocks
// Notes:   interval counts are judged within one step of slack
`timescale 1ns/10ps

module led_training_timeout_capture_tb;
  import led_train_pkg::*;
  localparam int tk = 4; // short time base keeps saturation runs small

  logic            clk;
  logic            nrst;
  logic            ctrl;
  logic            train_start;
  logic            train_end;
  logic            led_out;
  logic            training;
  logic            programmed;
  logic [1:0]      pair_cnt;
  logic [2:0][7:0] on_time;
  logic [2:0][7:0] off_time;
  int              errors;
  int              tests_run;

  led_host #(.tk(tk)) i_host (.clk(clk), .ctrl(ctrl), .train_start(train_start),
    .train_end(train_end));

  led_train_capture #(.TICK_CYCLES(tk)) i_dut (.clk(clk), .nrst(nrst), .ctrl(ctrl),
    .train_start(train_start), .train_end(train_end), .led_out(led_out),
    .training(training), .programmed(programmed), .pair_cnt(pair_cnt),
    .on_time(on_time), .off_time(off_time));

  // exact compare of a design value
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // compare of a one-bit status output
  task automatic chk_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: flag got %b expected %b", $time, got, exp);
    end
  endtask

  // compare of the stored pair count
  task automatic chk_cnt(input logic [1:0] got, input logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: pairs got %h expected %h", $time, got, exp);
    end
  endtask

  // range compare; the free time base may shorten the first step
  task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    tests_run++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      errors++;
      $display("mismatch at %0t: got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask

  // plain pair, then end during an on capture drops it
  task automatic plain_pair();
    i_host.cmd(1'b0);
    i_host.hold(1'b1, 20);
    chk_flag(led_out, 1'b1);
    i_host.hold(1'b0, 50);
    chk_flag(led_out, 1'b0);
    chk_rng(on_time[0], 8'h13, 8'h15);
    i_host.hold(1'b1, 10);
    chk_rng(off_time[0], 8'h04, 8'h06);
    chk_cnt(pair_cnt, 2'h1);
    chk_flag(programmed, 1'b1);
    i_host.cmd(1'b1);
    i_host.hold(1'b0, 1);
    chk_cnt(pair_cnt, 2'h1);
    chk_flag(training, 1'b0);
  endtask

  // three short pairs fill the memory; the next rise ends training
  task automatic three_pairs();
    i_host.cmd(1'b0);
    repeat (3) begin
      i_host.hold(1'b1, 3);
      i_host.hold(1'b0, 10);
    end
    i_host.hold(1'b1, 1);
    chk_cnt(pair_cnt, 2'h3);
    chk_flag(training, 1'b0);
    chk_rng(on_time[2], 8'h02, 8'h04);
    chk_rng(off_time[2], 8'h01, 8'h02);
    i_host.hold(1'b0, 1);
  endtask

  // on saturation, rise ends off, then on and off both saturate
  task automatic on_sat();
    i_host.cmd(1'b0);
    i_host.hold(1'b1, 270);
    chk_flag(led_out, 1'b0);
    chk(on_time[0], 8'hff);
    i_host.hold(1'b0, 30);
    i_host.hold(1'b1, 5);
    // off timing starts at saturation, so the high time after it counts too
    chk_rng(off_time[0], 8'h04, 8'h05);
    chk_flag(led_out, 1'b1);
    i_host.hold(1'b1, 2780);
    chk(on_time[1], 8'hff);
    chk(off_time[1], 8'hfa);
    chk_cnt(pair_cnt, 2'h2);
    chk_flag(training, 1'b1);
    i_host.hold(1'b0, 1);
    chk_flag(training, 1'b0);
  endtask

  // line left low until the off counter gives up
  task automatic off_idle();
    i_host.cmd(1'b0);
    i_host.hold(1'b1, 5);
    i_host.hold(1'b0, 2520);
    chk_rng(on_time[0], 8'h04, 8'h06);
    chk(off_time[0], 8'hfa);
    chk_cnt(pair_cnt, 2'h1);
    chk_flag(training, 1'b0);
  endtask

  // end command during off capture keeps the pair; start then end clears memory
  task automatic end_cmds();
    i_host.cmd(1'b0);
    i_host.hold(1'b1, 3);
    i_host.hold(1'b0, 10);
    i_host.cmd(1'b1);
    chk_cnt(pair_cnt, 2'h1);
    chk_rng(off_time[0], 8'h01, 8'h02);
    chk_flag(training, 1'b0);
    i_host.cmd(1'b0);
    i_host.cmd(1'b1);
    chk_flag(programmed, 1'b0);
    chk_cnt(pair_cnt, 2'h0);
    chk(on_time[0], 8'h00);
    chk(off_time[0], 8'h00);
  endtask

  // verdict and end of run
  task automatic complete_run();
    if (errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // free running clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // watchdog well beyond the expected 23k cycles
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    complete_run();
  end

  // main sequence
  initial begin
    errors = 0;
    tests_run = 0;
    nrst = 1'b0;
    repeat (16) @(negedge clk);
    chk({3'h0, led_out, training, programmed, pair_cnt}, 8'h00);
    nrst = 1'b1;
    plain_pair();
    three_pairs();
    on_sat();
    off_idle();
    end_cmds();
    complete_run();
  end
endmodule

//--- logic/led_train_capture.sv
// Purpose: training capture of a one-wire blink programmer
// Assumes: command decoder supplies start and end pulses
// Notes:   all outputs are registered, one cycle behind the line
//
// Functional notes
// - led mirrors command line while training, except while the line stays high after an on saturation
// - store one to three on/off pairs
// - on saturation records max, starts off timing
// - on saturation turns led off at once
// - off capture ends by end command, rise or off saturation
// - rise records off, starts next on capture unless the memory is full
// - high past off timeout saturates off counter
// - after off saturation wait fall, then standby
// - off saturates without end or new on
`timescale 1ns/10ps
`include "led_train_cfg.svh"

module led_train_capture
  import led_train_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYC // 1 ms time base in clocks
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // command line and decoded commands
  input  wire logic            ctrl,
  input  wire logic            train_start,
  input  wire logic            train_end,
  // led and stored sequence
  output logic                 led_out,
  output logic                 training,
  output logic                 programmed,
  output logic [1:0]           pair_cnt,
  output logic [2:0][7:0]      on_time,
  output logic [2:0][7:0]      off_time
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  train_type q;  // registered state
  train_type d;  // next state
  logic      rise; // command line went high
  logic      fall; // command line went low

  // edge detect against the registered level
  assign rise = ctrl & ~q.prev;
  assign fall = ~ctrl & q.prev;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // the prescaler runs free so no start command resets the tick phase;
  // the first step of an interval may therefore be up to one step short, 1 ms for on and 10 ms for off
  always_comb begin
    d          = q;
    d.prev     = ctrl;
    d.led      = 1'b0;
    d.tick_on  = 1'b0;
    d.tick_off = 1'b0;
    // free-running time base
    if (q.pre == 24'(TICK_CYCLES - 1)) begin
      d.pre     = 24'h00_0000;
      d.tick_on = 1'b1;
      if (q.dec == `OFF_STEP_TICKS) begin
        d.dec      = 4'h0;
        d.tick_off = 1'b1;
      end else begin
        d.dec = q.dec + 4'h1;
      end
    end else begin
      d.pre = q.pre + 24'h00_0001;
    end
    unique case (q.st)
      // standby: a start command clears the memory
      ST_IDLE: begin
        if (train_start) begin
          d.st    = ST_ARM;
          d.slot  = 2'h0;
          d.on_t  = '0;
          d.off_t = '0;
        end
      end
      // waiting for the first rising edge
      ST_ARM: begin
        d.led = ctrl;
        if (train_end) begin
          d.st = ST_IDLE; // empty sequence stays unprogrammed
        end else if (rise) begin
          d.st     = ST_ON;
          d.on_cnt = 8'h00;
        end
      end
      // on capture
      ST_ON: begin
        d.led = ctrl;
        if (train_end) begin
          d.st = ST_IDLE; // open on interval is dropped
        end else if (fall) begin
          d.on_t[q.slot] = q.on_cnt;
          d.st           = ST_OFF;
          d.off_cnt      = 8'h00;
        end else if (q.on_cnt == `ON_SAT) begin
          d.on_t[q.slot] = `ON_SAT;
          d.st           = ST_OFF;
          d.off_cnt      = 8'h00;
          d.led          = 1'b0; // line may still be high
        end else if (q.tick_on) begin
          d.on_cnt = q.on_cnt + 8'h01; // stops at max
        end
      end
      // off capture
      ST_OFF: begin
        if (train_end) begin
          d.off_t[q.slot] = q.off_cnt;
          d.slot          = q.slot + 2'h1;
          d.st            = ST_IDLE;
        end else if (rise) begin
          d.off_t[q.slot] = q.off_cnt;
          d.slot          = q.slot + 2'h1;
          d.on_cnt        = 8'h00;
          // memory full: no room for a fourth pair
          d.st            = (q.slot == `PAIR_LAST) ? ST_IDLE : ST_ON;
          d.led           = (q.slot != `PAIR_LAST);
        end else if (q.off_cnt == `OFF_SAT) begin
          d.off_t[q.slot] = `OFF_SAT;
          d.slot          = q.slot + 2'h1;
          d.st            = ST_HOLD;
        end else if (q.tick_off) begin
          d.off_cnt = q.off_cnt + 8'h01;
        end
      end
      // saturated off: wait for the line to drop
      ST_HOLD: begin
        if (!ctrl) begin
          d.st = ST_IDLE;
        end
      end
    endcase
    d.busy = (d.st != ST_IDLE);
    d.prog = (d.slot != 2'h0);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset loads constants only; the line level is caught after release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q    <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state flops
  assign led_out    = q.led;
  assign training   = q.busy;
  assign programmed = q.prog;
  assign pair_cnt   = q.slot;
  assign on_time    = q.on_t;
  assign off_time   = q.off_t;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // a saturation and its record, step by step; three of the checks below build on these
  sequence s_on_sat;
    q.st == ST_ON && !train_end && !fall && q.on_cnt == `ON_SAT;
  endsequence

  sequence s_off_rec;
    q.st == ST_OFF && !train_end && !rise && q.off_cnt == `OFF_SAT;
  endsequence

  chk_on_sat_rec: assert property (s_on_sat |=> q.st == ST_OFF && q.off_cnt == 8'h00
      && q.on_t[$past(q.slot)] == `ON_SAT)
    else $error("on saturation not recorded");
  chk_led_sat_off: assert property (s_on_sat ##1 ctrl |-> !led_out)
    else $error("led still on after on saturation");
  chk_led_mirror: assert property (q.st == ST_ON && !train_end && q.on_cnt != `ON_SAT
      |=> led_out == $past(ctrl))
    else $error("led does not follow command line");
  chk_on_max: assert property (q.on_cnt <= `ON_SAT && q.off_cnt <= `OFF_SAT)
    else $error("interval counter beyond maximum");
  chk_off_sat_hold: assert property (s_off_rec |=> q.st == ST_HOLD
      && pair_cnt == $past(pair_cnt) + 2'h1
      ##1 ($past(ctrl) ? q.st == ST_HOLD : !training))
    else $error("off saturation not recorded");
  chk_hold_fall: assert property (q.st == ST_HOLD && !ctrl |=> !training)
    else $error("no standby after line fall");
  chk_rise_next_on: assert property (q.st == ST_OFF && rise && !train_end
      && q.slot != `PAIR_LAST |=> q.st == ST_ON && q.on_cnt == 8'h00 && led_out)
    else $error("rise did not start next on capture");
  chk_end_off_rec: assert property (q.st == ST_OFF && train_end
      |=> !training && pair_cnt == $past(pair_cnt) + 2'h1)
    else $error("end command lost off interval");
  chk_end_on_drop: assert property (q.st == ST_ON && train_end
      |=> !training && pair_cnt == $past(pair_cnt))
    else $error("open on interval was stored");
  chk_off_low_sat: assert property (q.st == ST_OFF && !ctrl && !train_end
      && q.off_cnt == `OFF_SAT ##1 !ctrl |-> q.st == ST_HOLD ##1 !training)
    else $error("idle off timeout did not end training");

  // the on counter steps by one below its maximum or reloads at a rise; a wrap
  // from the maximum to zero without a rise would corrupt a saturated record
  chk_on_no_wrap: assert property (q.on_cnt != $past(q.on_cnt)
      |-> ($past(q.on_cnt) != `ON_SAT && q.on_cnt == $past(q.on_cnt) + 8'h01)
        || (q.on_cnt == 8'h00 && $past(rise)))
    else $error("on counter wrapped or jumped");

  // the off counter steps by one below its maximum or reloads on leaving on capture
  chk_off_no_wrap: assert property (q.off_cnt != $past(q.off_cnt)
      |-> ($past(q.off_cnt) != `OFF_SAT && q.off_cnt == $past(q.off_cnt) + 8'h01)
        || (q.off_cnt == 8'h00 && $past(q.st) == ST_ON))
    else $error("off counter wrapped or jumped");

endmodule

//--- logic/led_train_cfg.svh
// Purpose: timing and limit constants of the training capture block
// Assumes: 125 MHz clock
// Notes:   the time base tick is 1 ms, off counts in 10 ms steps
`ifndef LED_TRAIN_CFG_SVH
`define LED_TRAIN_CFG_SVH
`define CLK_PERIOD_NS 8
`define TICK_NS       1000000
`define TICK_CYC      (`TICK_NS / `CLK_PERIOD_NS)
`define OFF_STEP_TICKS 4'h9
`define ON_SAT        8'hff
`define OFF_SAT       8'hfa
`define PAIR_LAST     2'h2
`endif

//--- logic/led_train_pkg.sv
// Purpose: types of the training capture block
// Assumes: one-hot state codes
// Notes:   all state sits in one packed struct
package led_train_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_ARM  = 5'b0_0010,
    ST_ON   = 5'b0_0100,
    ST_OFF  = 5'b0_1000,
    ST_HOLD = 5'b1_0000
  } state_type;

  typedef struct packed {
    state_type       st;       // capture phase
    logic [23:0]     pre;      // clock prescaler
    logic [3:0]      dec;      // 1 ms ticks within one off step
    logic            tick_on;  // 1 ms step
    logic            tick_off; // 10 ms step
    logic [7:0]      on_cnt;   // running on interval
    logic [7:0]      off_cnt;  // running off interval
    logic [1:0]      slot;     // pairs recorded
    logic [2:0][7:0] on_t;     // stored on intervals
    logic [2:0][7:0] off_t;    // stored off intervals
    logic            led;      // led drive
    logic            prev;     // last command level
    logic            busy;     // training active
    logic            prog;     // sequence valid
  } train_type;
endpackage
